// >>> hw/ifcap_regs.vh
`ifndef IFCAP_REGS_VH
`define IFCAP_REGS_VH

// ****************************************
// Register offsets (byte addresses, one 32-bit word apart)
// ****************************************
`define IFCAP_ADDR_W 8
`define IFCAP_OFF_FLAG 8'h00
`define IFCAP_OFF_ROUTE 8'h04
`define IFCAP_OFF_EN 8'h08
`define IFCAP_OFF_CHSTAT 8'h0c
`define IFCAP_OFF_CHSET 8'h10
`define IFCAP_OFF_CHCLR 8'h14
`define IFCAP_OFF_ISTAT 8'h18
`define IFCAP_OFF_IMASK 8'h1c
`define IFCAP_OFF_PEND 8'h20

// ****************************************
// Reset values and field layout
// ****************************************
`define IFCAP_RST_ZERO 32'h0000_0000
`define IFCAP_IS_FAST 0
`define IFCAP_IS_NORM 1
`define IFCAP_IS_CHIP 2
`define IFCAP_IS_W 3

`endif

// >>> hw/ifcap_flag_bank.v
`timescale 1ns/1ps
`default_nettype none
module ifcap_flag_bank #(
  parameter N = 8
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Sources and clear
  input wire [N-1:0] src_in,
  input wire [N-1:0] clr_in,
  // Flags
  output reg [N-1:0] flag_ff
);
  wire [N-1:0] nxt_flag;

  // Any high input sets; a held level keeps re-setting, set wins over clear
  assign nxt_flag = src_in | (flag_ff & ~clr_in);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      flag_ff <= {N{1'b0}};
    end else begin
      flag_ff <= nxt_flag;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ifcap_chip_sig.v
`timescale 1ns/1ps
`default_nettype none
module ifcap_chip_sig #(
  parameter M = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Set from other processors or software, clear by write-one
  input wire [M-1:0] set_in,
  input wire [M-1:0] clr_in,
  // Status, which also is the level line to the controller
  output reg [M-1:0] status_ff
);
  wire [M-1:0] nxt_status;

  // A new signal in the clearing cycle is kept
  assign nxt_status = set_in | (status_ff & ~clr_in);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      status_ff <= {M{1'b0}};
    end else begin
      status_ff <= nxt_status;
    end
  end
endmodule
`default_nettype wire

// >>> hw/ifcap_top.v
// Contract
// - Route active flags to fast or normal output
// - Every input is treated as a pulse
// - Chip-signal line is level while status set
// - Held level registers as repeated pulses
// - One flag per source, no count
// - Flag holds until software clears it
// - Clear during held level re-sets flag
// - Write-one to clear drops level line
`timescale 1ns/1ps
`default_nettype none
`include "ifcap_regs.vh"
module ifcap_top #(
  parameter NSYS = 8,
  parameter NCHIP = 4
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Plain system interrupt sources
  input wire [NSYS-1:0] sys_irq_in,
  // Chip-signal set requests from other processors
  input wire [NCHIP-1:0] chip_signal_set_in,
  // Register port
  input wire [`IFCAP_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // Processor interrupt outputs
  output reg fast_irq_out_ff,
  output reg norm_irq_out_ff,
  // Block interrupt
  output reg blk_irq_ff
);
  // ****************************************
  // Sources and decode
  // ****************************************
  localparam NSRC = NSYS + NCHIP;

  function wr_hit;
    input [`IFCAP_ADDR_W-1:0] a;
    input [`IFCAP_ADDR_W-1:0] off;
    begin
      wr_hit = reg_wr && (a == off);
    end
  endfunction

  wire [NCHIP-1:0] chip_signal_status_reg;
  wire [NSRC-1:0] flags;
  wire [NSRC-1:0] src_all;
  wire [NSRC-1:0] flag_clr;
  wire [NCHIP-1:0] chip_sw_set;
  wire [NCHIP-1:0] chip_clr;
  reg [NSRC-1:0] route_ff;
  reg [NSRC-1:0] en_ff;
  reg [`IFCAP_IS_W-1:0] istat_ff;
  reg [`IFCAP_IS_W-1:0] imask_ff;
  reg [NSRC-1:0] flags_q_ff;
  reg [NCHIP-1:0] chst_q_ff;
  wire [NSRC-1:0] pend;
  wire [`IFCAP_IS_W-1:0] ev;
  reg [31:0] nxt_rdata;

  // Chip-signal status lines act as level interrupt inputs
  assign src_all = {chip_signal_status_reg, sys_irq_in};
  assign flag_clr = wr_hit(reg_addr, `IFCAP_OFF_FLAG) ? reg_wdata[NSRC-1:0] : {NSRC{1'b0}};
  assign chip_sw_set = wr_hit(reg_addr, `IFCAP_OFF_CHSET) ? reg_wdata[NCHIP-1:0] : {NCHIP{1'b0}};
  assign chip_clr = wr_hit(reg_addr, `IFCAP_OFF_CHCLR) ? reg_wdata[NCHIP-1:0] : {NCHIP{1'b0}};

  // ****************************************
  // Submodules
  // ****************************************
  ifcap_chip_sig #(.M(NCHIP)) u_chip (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .set_in(chip_signal_set_in | chip_sw_set),
    .clr_in(chip_clr),
    .status_ff(chip_signal_status_reg)
  );

  ifcap_flag_bank #(.N(NSRC)) u_flags (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .src_in(src_all),
    .clr_in(flag_clr),
    .flag_ff(flags)
  );

  // ****************************************
  // Routing and events
  // ****************************************
  assign pend = flags & en_ff;
  // New fast, new normal, new chip-signal status
  assign ev[`IFCAP_IS_FAST] = |(pend & route_ff & ~flags_q_ff);
  assign ev[`IFCAP_IS_NORM] = |(pend & ~route_ff & ~flags_q_ff);
  assign ev[`IFCAP_IS_CHIP] = |(chip_signal_status_reg & ~chst_q_ff);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      route_ff <= {NSRC{1'b0}};
      en_ff <= {NSRC{1'b0}};
      istat_ff <= {`IFCAP_IS_W{1'b0}};
      imask_ff <= {`IFCAP_IS_W{1'b0}};
      flags_q_ff <= {NSRC{1'b0}};
      chst_q_ff <= {NCHIP{1'b0}};
      fast_irq_out_ff <= 1'b0;
      norm_irq_out_ff <= 1'b0;
      blk_irq_ff <= 1'b0;
      reg_rdata_ff <= `IFCAP_RST_ZERO;
    end else begin
      if (wr_hit(reg_addr, `IFCAP_OFF_ROUTE)) begin
        route_ff <= reg_wdata[NSRC-1:0];
      end
      if (wr_hit(reg_addr, `IFCAP_OFF_EN)) begin
        en_ff <= reg_wdata[NSRC-1:0];
      end
      if (wr_hit(reg_addr, `IFCAP_OFF_IMASK)) begin
        imask_ff <= reg_wdata[`IFCAP_IS_W-1:0];
      end
      // Set wins over write-one clear
      if (wr_hit(reg_addr, `IFCAP_OFF_ISTAT)) begin
        istat_ff <= ev | (istat_ff & ~reg_wdata[`IFCAP_IS_W-1:0]);
      end else begin
        istat_ff <= ev | istat_ff;
      end
      flags_q_ff <= pend;
      chst_q_ff <= chip_signal_status_reg;
      fast_irq_out_ff <= |(pend & route_ff);
      norm_irq_out_ff <= |(pend & ~route_ff);
      blk_irq_ff <= |(istat_ff & imask_ff);
      reg_rdata_ff <= nxt_rdata;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    nxt_rdata = `IFCAP_RST_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        `IFCAP_OFF_FLAG: nxt_rdata[NSRC-1:0] = flags;
        `IFCAP_OFF_ROUTE: nxt_rdata[NSRC-1:0] = route_ff;
        `IFCAP_OFF_EN: nxt_rdata[NSRC-1:0] = en_ff;
        `IFCAP_OFF_CHSTAT: nxt_rdata[NCHIP-1:0] = chip_signal_status_reg;
        `IFCAP_OFF_ISTAT: nxt_rdata[`IFCAP_IS_W-1:0] = istat_ff;
        `IFCAP_OFF_IMASK: nxt_rdata[`IFCAP_IS_W-1:0] = imask_ff;
        `IFCAP_OFF_PEND: nxt_rdata[NSRC-1:0] = pend;
        default: nxt_rdata = `IFCAP_RST_ZERO;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verification/ifcap_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Source model
// ****
module ifcap_src_model (
  // Clock
  input wire logic sys_clk,
  // Requests from bench
  input wire logic [7:0] sys_req,
  input wire logic [3:0] chip_req,
  // Lines into the block
  output logic [7:0] sys_irq_in = 8'h00,
  output logic [3:0] chip_signal_set_in = 4'h0
);
  always @(posedge sys_clk) begin
    sys_irq_in <= sys_req;
    chip_signal_set_in <= chip_req;
  end
endmodule
`default_nettype wire

// >>> verification/ifcap_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Port checks
// ****
module ifcap_top_chk #(parameter NSYS = 8, parameter NCHIP = 4) (
  // Clock, reset, inputs
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [NSYS-1:0] sys_irq_in,
  input wire logic [NCHIP-1:0] chip_signal_set_in,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  // Outputs
  input wire logic [31:0] reg_rdata_ff,
  input wire logic fast_irq_out_ff,
  input wire logic norm_irq_out_ff,
  input wire logic blk_irq_ff
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // No cause for a new flag in the last cycles
  sequence s_calm;
    !$past(reg_wr) && !$past(reg_wr, 2) && $past(sys_irq_in) == '0 && $past(sys_irq_in, 2) == '0
    && $past(chip_signal_set_in, 2) == '0 && $past(chip_signal_set_in, 3) == '0;
  endsequence
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata_ff == 32'h0) else $error("rdata not idle");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr > 8'h20 |=> reg_rdata_ff == 32'h0) else $error("unmapped read");
  AST_RST: assert property (disable iff (1'b0) !rst_n |=> !fast_irq_out_ff && !norm_irq_out_ff && !blk_irq_ff)
    else $error("outputs not reset");
  AST_FAST_HOLD: assert property (fast_irq_out_ff && !$past(reg_wr) |=> fast_irq_out_ff) else $error("fast dropped");
  AST_NORM_HOLD: assert property (norm_irq_out_ff && !$past(reg_wr) |=> norm_irq_out_ff) else $error("norm dropped");
  AST_FAST_QUIET: assert property (!fast_irq_out_ff ##0 s_calm |=> !fast_irq_out_ff) else $error("fast no cause");
  AST_NORM_QUIET: assert property (!norm_irq_out_ff ##0 s_calm |=> !norm_irq_out_ff) else $error("norm no cause");
  AST_BLK_HOLD: assert property (blk_irq_ff && !$past(reg_wr) |=> blk_irq_ff) else $error("block irq dropped");
endmodule
bind ifcap_top ifcap_top_chk #(.NSYS(NSYS), .NCHIP(NCHIP)) i_chk (.sys_clk, .rst_n, .sys_irq_in,
  .chip_signal_set_in, .reg_addr, .reg_wr, .reg_rd, .reg_rdata_ff, .fast_irq_out_ff, .norm_irq_out_ff, .blk_irq_ff);
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ifcap_regs.vh"
// ****
// Bench
// ****
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sys_req = 8'h00;
  logic [3:0] chip_req = 4'h0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  wire [7:0] sys_irq_in;
  wire [3:0] chip_signal_set_in;
  wire [31:0] reg_rdata_ff;
  wire fast_irq_out_ff;
  wire norm_irq_out_ff;
  wire blk_irq_ff;
  int error_cnt = 0;
  int checked = 0;
  always #4 sys_clk = ~sys_clk;
  ifcap_src_model i_ifcap_src_model (.sys_clk, .sys_req, .chip_req, .sys_irq_in, .chip_signal_set_in);
  ifcap_top i_ifcap_top (.sys_clk, .rst_n, .sys_irq_in, .chip_signal_set_in, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_ff, .fast_irq_out_ff, .norm_irq_out_ff, .blk_irq_ff);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge sys_clk) reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge sys_clk) reg_rd <= 1'b0;
    #1 chk(reg_rdata_ff, exp);
  endtask
  // One-cycle source pulse, then time for flag and output
  task automatic pulse(input logic [7:0] s, input logic [3:0] c);
    @(posedge sys_clk) {sys_req, chip_req} <= {s, c};
    @(posedge sys_clk) {sys_req, chip_req} <= 12'h000;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'h40, 32'h0);
    wr(`IFCAP_OFF_EN, 32'h101);
    wr(`IFCAP_OFF_ROUTE, 32'h1);
    wr(`IFCAP_OFF_IMASK, 32'h7);
    pulse(8'h01, 4'h0);
    chk({31'h0, fast_irq_out_ff}, 32'h1);
    chk({31'h0, norm_irq_out_ff}, 32'h0);
    pulse(8'h01, 4'h0);
    rd(`IFCAP_OFF_FLAG, 32'h1);
    wr(`IFCAP_OFF_FLAG, 32'h1);
    rd(`IFCAP_OFF_FLAG, 32'h0);
    chk({31'h0, fast_irq_out_ff}, 32'h0);
    pulse(8'h00, 4'h1);
    rd(`IFCAP_OFF_CHSTAT, 32'h1);
    rd(`IFCAP_OFF_FLAG, 32'h100);
    chk({31'h0, norm_irq_out_ff}, 32'h1);
    // Flag cleared too early comes straight back
    wr(`IFCAP_OFF_FLAG, 32'h100);
    rd(`IFCAP_OFF_FLAG, 32'h100);
    wr(`IFCAP_OFF_CHCLR, 32'h1);
    rd(`IFCAP_OFF_CHSTAT, 32'h0);
    wr(`IFCAP_OFF_FLAG, 32'h100);
    rd(`IFCAP_OFF_FLAG, 32'h0);
    chk({31'h0, norm_irq_out_ff}, 32'h0);
    chk({31'h0, blk_irq_ff}, 32'h1);
    rd(`IFCAP_OFF_ISTAT, 32'h7);
    wr(`IFCAP_OFF_IMASK, 32'h0);
    // Block output is one register behind the mask
    @(posedge sys_clk);
    #1;
    chk({31'h0, blk_irq_ff}, 32'h0);
    wr(`IFCAP_OFF_ISTAT, 32'h7);
    rd(`IFCAP_OFF_ISTAT, 32'h0);
    rd(`IFCAP_OFF_ROUTE, 32'h1);
    rd(`IFCAP_OFF_EN, 32'h101);
    rd(`IFCAP_OFF_IMASK, 32'h0);
    // Software-set chip signal on a source left disabled
    wr(`IFCAP_OFF_CHSET, 32'h2);
    rd(`IFCAP_OFF_CHSTAT, 32'h2);
    rd(`IFCAP_OFF_FLAG, 32'h200);
    rd(`IFCAP_OFF_PEND, 32'h0);
    chk({31'h0, norm_irq_out_ff}, 32'h0);
    wr(`IFCAP_OFF_CHCLR, 32'h2);
    rd(`IFCAP_OFF_CHSTAT, 32'h0);
    wr(`IFCAP_OFF_FLAG, 32'h200);
    rd(`IFCAP_OFF_FLAG, 32'h0);
    close_out;
  end
  initial begin
    #20000;
    error_cnt++;
    close_out;
  end
endmodule
`default_nettype wire
